/* logic/asm_cmd.v */
`timescale 1ns/1ps
`include "asm_consts.vh"
module asm_cmd
#(
  parameter SLEEP_CYC = `ASM_SLEEP_MS * `ASM_CLK_KHZ,
  parameter MAX_BLOCK = `ASM_MAX_BLOCK
)
(
  // Clock and resets
  input wire sys_clk,
  input wire reset_n,
  input wire soft_reset,
  // Task file, command strobe and statistic source
  input wire cmd_strobe,
  input wire [7:0] cmd_code,
  input wire [7:0] feature,
  input wire [7:0] sec_count,
  input wire [7:0] sec_num,
  input wire [7:0] cyl_low,
  input wire [7:0] cyl_high,
  input wire [15:0] stat_value,
  // Data read stream
  input wire data_ready,
  output wire data_valid,
  output reg [7:0] data_byte,
  // Status towards host
  output reg busy,
  output reg abort_err,
  output reg host_irq,
  output reg sleeping,
  output reg smart_on,
  output reg mult_on,
  output reg [7:0] mult_count,
  output reg [7:0] stat_sel,
  output reg [7:0] coll_status
);
  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  localparam S_IDLE = 5'b00001;
  localparam S_EXEC = 5'b00010;
  localparam S_COLLECT = 5'b00100;
  localparam S_STREAM = 5'b01000;
  localparam S_DONE = 5'b10000;
  // Last idle count before sleep, kept at the counter's own width
  localparam [31:0] SLEEP_LAST = SLEEP_CYC - 1;

  reg [4:0] state;
  // Task file latched at the command strobe
  reg [7:0] op;
  reg [7:0] sub;
  reg [7:0] arg_cnt;
  reg [7:0] arg_num;
  reg sig_ok;
  // Collection, stream and power bookkeeping
  reg [15:0] coll_cnt;
  reg [15:0] coll_data;
  reg coll_valid;
  reg por_on_soft;
  reg [8:0] idx;
  reg [31:0] idle_cnt;
  reg fail;
  reg [7:0] raw_byte;
  wire [7:0] check;

  function is_code;
    input [7:0] c;
    begin
      is_code = (c >= `ASM_CODE_FIRST) && (c <= `ASM_CODE_LAST);
    end
  endfunction

  function [7:0] layout;
    input [8:0] i;
    input [7:0] st;
    input [7:0] sel;
    input [15:0] d;
    begin
      // Byte 0 names the statistic, the next two carry it MSB first.
      // Every unused byte reads as zero, so it adds nothing to the sum
      // and the checksum depends only on the few live bytes.
      if (i == `ASM_SEL_BYTE)
        layout = sel;
      else if (i == `ASM_VAL_MSB)
        layout = d[15:8];
      else if (i == `ASM_VAL_LSB)
        layout = d[7:0];
      else if (i == `ASM_STD_FIRST)
        layout = st;
      else
        layout = 8'h00;
    end
  endfunction

  // ----------------------------------------------------------------
  // Stream handshake
  // ----------------------------------------------------------------
  // A byte moves only when the host takes it, so a slow host just
  // stretches the stream; the checksum byte itself is never summed.
  wire in_stream;
  wire take_byte;
  wire sum_byte;

  assign in_stream = (state == S_STREAM);
  assign take_byte = in_stream && data_ready;
  assign sum_byte = take_byte && (idx != `ASM_SUM_BYTE);

  // ----------------------------------------------------------------
  // Byte source and checksum
  // ----------------------------------------------------------------
  always @*
  begin
    raw_byte = layout(idx, coll_status, stat_sel, coll_data);
  end

  asm_sum u_sum
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(!in_stream),
    .add(sum_byte),
    .data(raw_byte),
    .check(check)
  );

  assign data_valid = in_stream;

  always @*
  begin
    if (idx == `ASM_SUM_BYTE)
      data_byte = check;
    else
      data_byte = raw_byte;
  end

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE;
      op <= 8'h00;
      sub <= 8'h00;
      arg_cnt <= 8'h00;
      arg_num <= 8'h00;
      sig_ok <= 1'b0;
      busy <= 1'b0;
      abort_err <= 1'b0;
      host_irq <= 1'b0;
      sleeping <= 1'b0;
      smart_on <= 1'b0;
      mult_on <= 1'b0;
      mult_count <= 8'h00;
      stat_sel <= 8'h00;
      coll_status <= `ASM_ST_NEVER;
      coll_valid <= 1'b0;
      coll_data <= 16'h0000;
      coll_cnt <= 16'h0000;
      por_on_soft <= 1'b1;
      idx <= 9'h000;
      idle_cnt <= 32'h0000_0000;
      fail <= 1'b0;
    end
    else
    begin
      host_irq <= 1'b0;
      // Software reset wins over any command still in flight
      if (soft_reset)
      begin
        // Collected data never survives a reset; mode only if defaults on
        state <= S_IDLE;
        busy <= 1'b0;
        coll_valid <= 1'b0;
        coll_status <= `ASM_ST_NEVER;
        sleeping <= 1'b0;
        if (por_on_soft)
          mult_on <= 1'b0;
      end
      else
      begin
        case (state)
          S_IDLE:
          begin
            if (cmd_strobe)
            begin
              op <= cmd_code;
              sub <= feature;
              arg_cnt <= sec_count;
              arg_num <= sec_num;
              sig_ok <= (cyl_high == `ASM_SIG_HIGH) &&
                (cyl_low == `ASM_SIG_LOW);
              busy <= 1'b1;
              abort_err <= 1'b0;
              sleeping <= 1'b0;
              idle_cnt <= 32'h0000_0000;
              state <= S_EXEC;
            end
            else if (!sleeping)
            begin
              // Counts only while idle and awake, so a long collection
              // or stream never drops the drive asleep mid-command
              if (idle_cnt >= SLEEP_LAST)
                sleeping <= 1'b1;
              else
                idle_cnt <= idle_cnt + 32'h0000_0001;
            end
          end
          S_EXEC:
          begin
            // Every command not cut short by soft_reset leaves through S_DONE, so busy, error and
            // interrupt then change together for the host
            fail <= 1'b0;
            state <= S_DONE;
            case (op)
              `ASM_OP_SMART:
              begin
                if (!sig_ok)
                  fail <= 1'b1;
                else if (sub == `ASM_SUB_ENABLE)
                  smart_on <= 1'b1;
                else if (!smart_on)
                  fail <= 1'b1;
                else if (sub == `ASM_SUB_DISABLE)
                  smart_on <= 1'b0;
                else if (sub == `ASM_SUB_OFFLINE)
                begin
                  if (is_code(arg_num))
                  begin
                    stat_sel <= arg_num;
                    coll_cnt <= `ASM_COLLECT_CYC;
                    state <= S_COLLECT;
                  end
                  else
                  begin
                    fail <= 1'b1;
                    coll_status <= `ASM_ST_DABORT;
                  end
                end
                else if (sub == `ASM_SUB_READ)
                begin
                  if (coll_valid)
                  begin
                    idx <= 9'h000;
                    state <= S_STREAM;
                  end
                  else
                    fail <= 1'b1;
                end
                else
                  fail <= 1'b1;
              end
              `ASM_OP_SETMULT:
              begin
                if (arg_cnt == 8'h00)
                  mult_on <= 1'b0;
                else if (arg_cnt <= MAX_BLOCK)
                begin
                  mult_count <= arg_cnt;
                  mult_on <= 1'b1;
                end
                else
                begin
                  fail <= 1'b1;
                  mult_on <= 1'b0;
                end
              end
              `ASM_OP_SLEEP_A, `ASM_OP_SLEEP_B,
              `ASM_OP_STBY_A, `ASM_OP_STBY_B:
                sleeping <= 1'b1;
              `ASM_OP_WRMULT, `ASM_OP_RDMULT:
                if (!mult_on)
                  fail <= 1'b1;
              `ASM_OP_SETFEAT:
              begin
                if (sub == `ASM_FEAT_POR_OFF)
                  por_on_soft <= 1'b0;
                else if (sub == `ASM_FEAT_POR_ON)
                  por_on_soft <= 1'b1;
              end
              default:
                fail <= 1'b0;
            endcase
          end
          S_COLLECT:
          begin
            // Captive: busy stays up until the statistic is latched
            // The statistic is sampled once, in the last counted cycle
            if (coll_cnt == `ASM_COLLECT_END)
            begin
              coll_data <= stat_value;
              coll_valid <= 1'b1;
              coll_status <= `ASM_ST_DONE;
              state <= S_DONE;
            end
            coll_cnt <= coll_cnt - `ASM_COLLECT_END;
          end
          S_STREAM:
          begin
            if (take_byte)
            begin
              if (idx == `ASM_LAST_IDX)
                state <= S_DONE;
              else
                idx <= idx + 9'h001;
            end
          end
          S_DONE:
          begin
            busy <= 1'b0;
            abort_err <= fail;
            host_irq <= 1'b1;
            state <= S_IDLE;
          end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end
endmodule

/* logic/asm_consts.vh */
`ifndef ASM_CONSTS_VH
`define ASM_CONSTS_VH
// Command opcodes
`define ASM_OP_SMART 8'hb0
`define ASM_OP_SETMULT 8'hc6
`define ASM_OP_SLEEP_A 8'he6
`define ASM_OP_SLEEP_B 8'h99
`define ASM_OP_STBY_A 8'he2
`define ASM_OP_STBY_B 8'h96
`define ASM_OP_WRMULT 8'hc5
`define ASM_OP_RDMULT 8'hc4
`define ASM_OP_SETFEAT 8'hef
// SMART subcommands and signature
`define ASM_SUB_READ 8'hd0
`define ASM_SUB_OFFLINE 8'hd4
`define ASM_SUB_ENABLE 8'hd8
`define ASM_SUB_DISABLE 8'hd9
`define ASM_SIG_HIGH 8'hc2
`define ASM_SIG_LOW 8'h4f
// Off-line collection codes
`define ASM_CODE_FIRST 8'hca
`define ASM_CODE_LAST 8'hd1
// Set-Features codes for software reset defaults
`define ASM_FEAT_POR_OFF 8'h66
`define ASM_FEAT_POR_ON 8'hcc
// Collection status values
`define ASM_ST_NEVER 8'h00
`define ASM_ST_DONE 8'h02
`define ASM_ST_SUSP 8'h04
`define ASM_ST_HABORT 8'h05
`define ASM_ST_DABORT 8'h06
// Data structure layout
`define ASM_STD_FIRST 9'h16a
`define ASM_STD_LAST 9'h181
`define ASM_SUM_BYTE 9'h1ff
`define ASM_LAST_IDX 9'h1ff
`define ASM_SEL_BYTE 9'h000
`define ASM_VAL_MSB 9'h001
`define ASM_VAL_LSB 9'h002
// Timing and block size limit
`define ASM_SLEEP_MS 15
`define ASM_CLK_KHZ 40000
`define ASM_COLLECT_CYC 16'h0010
`define ASM_COLLECT_END 16'h0001
`define ASM_MAX_BLOCK 8'h01
`endif

/* logic/asm_sum.v */
`timescale 1ns/1ps
`include "asm_consts.vh"
// Running byte sum that yields the two's-complement checksum byte
module asm_sum
(
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Control
  input wire clear,
  input wire add,
  input wire [7:0] data,
  // Result
  output reg [7:0] check
);
  reg [7:0] acc;
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      acc <= 8'h00;
    else if (clear)
      acc <= 8'h00;
    else if (add)
      acc <= acc + data;
  end
  always @*
  begin
    check = 8'h00 - acc;
  end
endmodule

/* sim/asm_cmd_monitor.sv */
`timescale 1ns/1ps
`include "asm_consts.vh"
module asm_cmd_monitor
#(
  parameter MAX_BLOCK = 1
)
(
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Task file
  input wire cmd_strobe,
  input wire [7:0] cmd_code,
  input wire [7:0] feature,
  input wire [7:0] sec_count,
  input wire [7:0] sec_num,
  input wire [7:0] cyl_low,
  input wire [7:0] cyl_high,
  // Status
  input wire busy,
  input wire abort_err,
  input wire host_irq,
  input wire sleeping,
  input wire smart_on,
  input wire mult_on,
  input wire [7:0] coll_status
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire take = cmd_strobe && !busy;
  wire op_sl = cmd_code == `ASM_OP_SLEEP_A || cmd_code == `ASM_OP_SLEEP_B;
  wire op_sb = cmd_code == `ASM_OP_STBY_A || cmd_code == `ASM_OP_STBY_B;
  wire smart = take && cmd_code == `ASM_OP_SMART &&
    cyl_high == `ASM_SIG_HIGH && cyl_low == `ASM_SIG_LOW;
  wire offl = smart && smart_on && feature == `ASM_SUB_OFFLINE;
  wire good = sec_num >= `ASM_CODE_FIRST && sec_num <= `ASM_CODE_LAST;
  wire setm = take && cmd_code == `ASM_OP_SETMULT;
  property p_offl_bad;
    offl && !good |-> ##[2:24]
      (host_irq && abort_err && coll_status == `ASM_ST_DABORT);
  endproperty
  a_offl_bad: assert property (p_offl_bad)
    else $error("reserved code not aborted");
  // Busy must stay up for the first 16 cycles after a captive collection is taken
  property p_captive;
    offl && good |=> busy[*8] ##1 busy[*8]
      ##[1:8] (host_irq && coll_status == `ASM_ST_DONE);
  endproperty
  a_captive: assert property (p_captive)
    else $error("collection not captive");
  property p_mult_bad;
    setm && sec_count > MAX_BLOCK |-> ##[2:4]
      (host_irq && abort_err && !mult_on);
  endproperty
  a_mult_bad: assert property (p_mult_bad)
    else $error("bad block size kept");
  property p_sleep;
    take && op_sl |-> ##[2:4] (host_irq && sleeping && !busy)
      ##1 !host_irq;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep sequence wrong");
  property p_stby;
    take && op_sb |=> busy ##[1:3] (host_irq && sleeping && !busy);
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby sequence wrong");
  property p_wake;
    sleeping && take && !op_sl && !op_sb |-> ##[1:4] !sleeping;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on command");
  property p_smart_off;
    smart && !smart_on && feature != `ASM_SUB_ENABLE |-> ##[2:4]
      (host_irq && abort_err);
  endproperty
  a_smart_off: assert property (p_smart_off)
    else $error("smart off not aborted");
  property p_wr_off;
    take && cmd_code == `ASM_OP_WRMULT && !mult_on |-> ##[2:4]
      (host_irq && abort_err);
  endproperty
  a_wr_off: assert property (p_wr_off)
    else $error("write multiple not refused");
  c_sleep: cover property (take && op_sl);
  c_coll: cover property (offl && good);
  c_mult: cover property (setm && sec_count == 8'h01);
endmodule

/* sim/asm_cmd_tb_top.sv */
`timescale 1ns/1ps
`include "asm_consts.vh"
module asm_cmd_tb_top;
  localparam SLEEP = 50;
  localparam MAXB = `ASM_MAX_BLOCK;
  reg sys_clk, reset_n, soft_reset, slow, ok;
  reg [15:0] stat_value;
  reg [31:0] seed, tmp;
  reg [7:0] rx [0:511];
  reg [7:0] code, sum;
  integer errors, n_tests, n_rx, i, s;
  wire cmd_strobe, data_ready, data_valid, busy, abort_err;
  wire host_irq, sleeping, smart_on, mult_on;
  wire [7:0] cmd_code, feature, sec_count, sec_num, cyl_low, cyl_high;
  wire [7:0] data_byte, mult_count, stat_sel, coll_status;
  asm_cmd #(.SLEEP_CYC(SLEEP)) asm_cmd_inst (.*);
  asm_host_model asm_host_model_inst (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = !sys_clk;
  end
  always @(posedge sys_clk)
    if (data_valid && data_ready && n_rx < 512)
    begin
      rx[n_rx] <= data_byte;
      n_rx <= n_rx + 1;
    end
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function good(input [7:0] c);
    good = c >= `ASM_CODE_FIRST && c <= `ASM_CODE_LAST;
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task cmd(input [31:0] tf, input sig);
    begin
      asm_host_model_inst.issue(tf, sig, ok);
      if (ok !== 1'b1)
      begin
        errors = errors + 1;
        report_and_stop;
      end
    end
  endtask
  task rd(input [7:0] c, input [15:0] v);
    begin
      n_rx = 0;
      slow = seed[5];
      cmd({`ASM_OP_SMART, `ASM_SUB_READ, 16'h0}, 1);
      for (s = 0; s < 1200 && data_valid !== 1'b0; s = s + 1)
      begin
        @(posedge sys_clk);
        #1;
      end
      #1;
      sum = 8'h00;
      for (s = 0; s < 512; s = s + 1)
        sum = sum + rx[s];
      check(n_rx[15:0], 16'd512);
      check(sum, 0);
      check(rx[362], `ASM_ST_DONE);
      check(rx[0], c);
      check({rx[1], rx[2]}, v);
      slow = 1'b0;
    end
  endtask
  initial
  begin
    {errors, n_tests, n_rx} = 0;
    seed = 32'h9fdf;
    {reset_n, soft_reset, slow} = 3'b000;
    stat_value = 16'h0000;
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    check(mult_on, 0);
    check(coll_status, `ASM_ST_NEVER);
    cmd({`ASM_OP_SMART, `ASM_SUB_READ, 16'h0}, 1);
    check(abort_err, 1);
    cmd({`ASM_OP_SMART, `ASM_SUB_ENABLE, 16'h0}, 0);
    check(smart_on, 0);
    cmd({`ASM_OP_SMART, `ASM_SUB_ENABLE, 16'h0}, 1);
    check(smart_on, 1);
    // Range edges first, then random codes, each either any byte or clustered near the range
    for (i = 0; i < 16; i = i + 1)
    begin
      seed = lfsr(seed);
      code = seed[8] ? seed[7:0] : {4'hc, seed[3:0]} + 8'h08;
      if (i < 4)
        code = 8'hc9 + {4'h0, i[1], 2'b00, i[0]};
      stat_value = seed[31:16];
      cmd({`ASM_OP_SMART, `ASM_SUB_OFFLINE, 8'h0, code}, 1);
      check(abort_err, !good(code));
      check(coll_status,
        good(code) ? `ASM_ST_DONE : `ASM_ST_DABORT);
      if (good(code))
      begin
        check(stat_sel, code);
        rd(code, stat_value);
      end
    end
    for (i = 0; i < 6; i = i + 1)
    begin
      seed = lfsr(seed);
      code = i < 3 ? i[7:0] : seed[7:0];
      cmd({`ASM_OP_SETMULT, 8'h0, code, 8'h0}, 1);
      check(abort_err, code > MAXB);
      check(mult_on, code != 0 && code <= MAXB);
      if (mult_on === 1'b1)
        check(mult_count, code);
    end
    cmd({`ASM_OP_SETMULT, 24'h000200}, 1);
    cmd({`ASM_OP_WRMULT, 24'h1}, 1);
    check(abort_err, 1);
    for (i = 0; i < 3; i = i + 1)
    begin
      code = i == 1 ? `ASM_FEAT_POR_OFF : `ASM_FEAT_POR_ON;
      cmd({`ASM_OP_SETFEAT, code, 16'h0}, 1);
      cmd({`ASM_OP_SETMULT, 24'h000100}, 1);
      @(posedge sys_clk);
      #1 soft_reset = 1'b1;
      @(posedge sys_clk);
      #1 soft_reset = 1'b0;
      check(mult_on, i == 1);
      check(coll_status, `ASM_ST_NEVER);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      tmp = 32'h96e299e6 >> (8 * i);
      cmd({tmp[7:0], 24'h0}, 1);
      check(sleeping, 1);
      cmd(32'h0, 1);
      check(sleeping, 0);
    end
    for (s = 0; s < 200 && sleeping !== 1'b1; s = s + 1)
    begin
      @(posedge sys_clk);
      #1;
    end
    check(s > SLEEP - 5 && s < 200, 1);
    if (s == 200)
      report_and_stop;
    cmd({`ASM_OP_SMART, `ASM_SUB_OFFLINE, 8'h0, `ASM_CODE_LAST}, 1);
    cmd({`ASM_OP_SETMULT, 24'h000100}, 1);
    @(posedge sys_clk);
    #1 reset_n = 1'b0;
    @(posedge sys_clk);
    #1 reset_n = 1'b1;
    check(coll_status, `ASM_ST_NEVER);
    check(mult_on, 0);
    report_and_stop;
  end
endmodule
bind asm_cmd asm_cmd_monitor #(.MAX_BLOCK(MAX_BLOCK)) asm_cmd_monitor_inst (.*);

/* sim/asm_host_model.sv */
`timescale 1ns/1ps
`include "asm_consts.vh"
module asm_host_model
(
  // Clock and device status
  input wire sys_clk,
  input wire host_irq,
  input wire slow,
  // Task file and stream acceptance
  output reg cmd_strobe,
  output reg [7:0] cmd_code,
  output reg [7:0] feature,
  output reg [7:0] sec_count,
  output reg [7:0] sec_num,
  output reg [7:0] cyl_low,
  output reg [7:0] cyl_high,
  output reg data_ready
);
  initial
  begin
    {cmd_strobe, cmd_code, feature, sec_count} = 25'h0;
    {sec_num, cyl_low, cyl_high} = 24'h0;
    data_ready = 1'b1;
  end
  // A slow host takes a byte only every other cycle
  always @(posedge sys_clk)
    data_ready <= #1 slow ? !data_ready : 1'b1;
  // One command; task file stays put until the next one
  task issue(input [31:0] tf, input sig_ok, output ok);
    integer i;
    begin
      @(posedge sys_clk);
      #1;
      {cmd_code, feature, sec_count, sec_num} = tf;
      cyl_high = sig_ok ? `ASM_SIG_HIGH : 8'h00;
      cyl_low = sig_ok ? `ASM_SIG_LOW : 8'h00;
      cmd_strobe = 1'b1;
      @(posedge sys_clk);
      #1;
      cmd_strobe = 1'b0;
      ok = 1'b0;
      for (i = 0; i < 2000 && ok !== 1'b1; i = i + 1)
      begin
        @(posedge sys_clk);
        #1;
        ok = host_irq;
      end
    end
  endtask
endmodule
